// >>> jbs_scan.v
// boundary scan and command handling of the serial debug port
// assumes tck, tms, tdi, trstN are asynchronous pins sampled by sys_clk
`timescale 1ns/1ps
`include "jbs_map.vh"
module jbs_scan #(
	parameter NPIN = 4,
	parameter NIN  = 4
) (
	input  wire            sys_clk,
	input  wire            srst,
	input  wire            tck,
	input  wire            tms,
	input  wire            tdi,
	input  wire            trstN,
	output reg             tdo,
	output reg             tdoOeN,
	input  wire            cpuSleep,
	input  wire            cpuStandby,
	output reg             wakeReq,
	output reg             dbgIntReq,
	input  wire            dbgIntTaken,
	output reg  [3:0]      irOut,
	output reg             cmdValid,
	input  wire            cmdReady,
	input  wire [NIN-1:0]  pinIn,
	output reg  [NIN-1:0]  coreIn,
	input  wire [NPIN-1:0] coreOut,
	input  wire [NPIN-1:0] coreOeN,
	input  wire [NPIN-1:0] padIn,
	output reg  [NPIN-1:0] padOut,
	output reg  [NPIN-1:0] padOeN,
	input  wire [1:0]      oscPins,
	input  wire            busClkPin
);
	// chain: two-way pins (in, out, ctl each), plain inputs, oscillator and bus clock
	// reset pins and the test port itself carry no cells
	localparam NCLK = 3;
	localparam LEN  = 3*NPIN + NIN + NCLK;

	// ********************************
	// pin synchronisers and tck edges
	// ********************************
	reg [1:0] s0Tck, s0Tms, s0Tdi, s0Rst;
	reg       tckD;
	reg [1:0] s0Clk, s0Bus;
	always @(posedge sys_clk) begin
		s0Tck <= {s0Tck[0], tck};
		s0Tms <= {s0Tms[0], tms};
		s0Tdi <= {s0Tdi[0], tdi};
		s0Rst <= {s0Rst[0], trstN};
		s0Clk <= {s0Clk[0], oscPins[0]};
		s0Bus <= {s0Bus[0], busClkPin};
		tckD  <= s0Tck[1];
	end
	wire tckRise = s0Tck[1] & ~tckD;
	wire tckFall = ~s0Tck[1] & tckD;
	wire tRst    = ~s0Rst[1];

	// ********************************
	// tap state machine
	// ********************************
	reg [3:0] st;
	reg [3:0] next_st;
	always @* begin
		case (st)
		`JBS_TLR:  next_st = s0Tms[1] ? `JBS_TLR  : `JBS_RTI;
		`JBS_RTI:  next_st = s0Tms[1] ? `JBS_SDRS : `JBS_RTI;
		`JBS_SDRS: next_st = s0Tms[1] ? `JBS_SIRS : `JBS_CDR;
		`JBS_CDR:  next_st = s0Tms[1] ? `JBS_E1DR : `JBS_SHDR;
		`JBS_SHDR: next_st = s0Tms[1] ? `JBS_E1DR : `JBS_SHDR;
		`JBS_E1DR: next_st = s0Tms[1] ? `JBS_UDR  : `JBS_PDR;
		`JBS_PDR:  next_st = s0Tms[1] ? `JBS_E2DR : `JBS_PDR;
		`JBS_E2DR: next_st = s0Tms[1] ? `JBS_UDR  : `JBS_SHDR;
		`JBS_UDR:  next_st = s0Tms[1] ? `JBS_SDRS : `JBS_RTI;
		`JBS_SIRS: next_st = s0Tms[1] ? `JBS_TLR  : `JBS_CIR;
		`JBS_CIR:  next_st = s0Tms[1] ? `JBS_E1IR : `JBS_SHIR;
		`JBS_SHIR: next_st = s0Tms[1] ? `JBS_E1IR : `JBS_SHIR;
		`JBS_E1IR: next_st = s0Tms[1] ? `JBS_UIR  : `JBS_PIR;
		`JBS_PIR:  next_st = s0Tms[1] ? `JBS_E2IR : `JBS_PIR;
		`JBS_E2IR: next_st = s0Tms[1] ? `JBS_UIR  : `JBS_SHIR;
		`JBS_UIR:  next_st = s0Tms[1] ? `JBS_SDRS : `JBS_RTI;
		default:   next_st = `JBS_TLR;
		endcase
	end

	// decoding used for both the scan path and the pin muxes
	function [1:0] selOf;
		input [3:0] c;
		begin
			case (c)
			`JBS_CMD_EXTEST: selOf = 2'h2;
			`JBS_CMD_SAMPLE: selOf = 2'h1;
			default:         selOf = 2'h0;
			endcase
		end
	endfunction

	// ********************************
	// instruction, bypass and boundary registers
	// ********************************
	reg [3:0]     irShift;
	reg [3:0]     ir;
	reg           bypassBit;
	reg [LEN-1:0] bsrShift;
	reg [LEN-1:0] bsrLatch;
	reg           sampleTdi;
	reg           armIr;
	reg           armDr;
	reg           latchValid;
	wire [1:0]    sel    = selOf(ir);
	wire          extest = (sel == 2'h2);
	wire [LEN-1:0] capVal;
	// two-way pin cells: input cell captures pad; output and control cells capture core, or keep shifted data under extest
	genvar g;
	generate
		for (g = 0; g < NPIN; g = g + 1) begin : gCell
			assign capVal[3*g]   = padIn[g];
			assign capVal[3*g+1] = extest ? bsrShift[3*g+1] : coreOut[g];
			assign capVal[3*g+2] = extest ? bsrShift[3*g+2] : coreOeN[g];
		end
	endgenerate
	assign capVal[LEN-1:3*NPIN] = {s0Bus[1], s0Clk[1], oscPins[1], pinIn};

	// buffer stands between the instruction update and the command consumer
	wire       bufInReady;
	wire       bufOutValid;
	wire [3:0] bufOutData;
	reg        pushCmd;
	reg [3:0]  pushData;
	jbs_buf2 #(.W(4)) uBuf (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.inValid  (pushCmd),
		.inReady  (bufInReady),
		.inData   (pushData),
		.outValid (bufOutValid),
		.outReady (cmdReady | ~cmdValid),
		.outData  (bufOutData)
	);

	always @(posedge sys_clk) begin
		if (srst || tRst) begin
			st         <= `JBS_TLR;
			ir         <= `JBS_CMD_BYPASS;
			irShift    <= `JBS_IR_CAPTURE;
			bypassBit  <= 1'b0;
			bsrShift   <= {LEN{1'b0}};
			bsrLatch   <= {LEN{1'b0}};
			latchValid <= 1'b0;
			sampleTdi  <= 1'b0;
			armIr      <= 1'b0;
			armDr      <= 1'b0;
			tdo        <= 1'b0;
			tdoOeN     <= 1'b1;
			pushCmd    <= 1'b0;
			pushData   <= 4'h0;
			wakeReq    <= 1'b0;
			dbgIntReq  <= 1'b0;
		end else begin
			pushCmd <= 1'b0;
			wakeReq <= 1'b0;
			if (tckRise) begin
				st        <= next_st;
				sampleTdi <= s0Tdi[1];
				// only a rise seen inside a shift state moves data at the next fall
				armIr     <= (st == `JBS_SHIR);
				armDr     <= (st == `JBS_SHDR);
				case (st)
				`JBS_CIR: irShift <= `JBS_IR_CAPTURE;
				`JBS_CDR: begin
					bypassBit <= 1'b0;
					if (sel != 2'h0)
						bsrShift <= capVal;
				end
				`JBS_UDR: if (sel != 2'h0) begin
					bsrLatch   <= bsrShift;
					latchValid <= 1'b1;
				end
				`JBS_UIR: if (!cpuStandby) begin
					ir       <= irShift;
					pushCmd  <= bufInReady;
					pushData <= irShift;
					wakeReq  <= (irShift == `JBS_CMD_WAKE) && cpuSleep;
					if (irShift == `JBS_CMD_DBGINT)
						dbgIntReq <= 1'b1;
				end
				`JBS_TLR: ir <= `JBS_CMD_BYPASS;
				default: ;
				endcase
			end
			if (tckFall) begin
				// shift on falling edge with the bit sampled at the rise;
				// the first fall after capture only presents bit 0
				if (armIr) begin
					tdo     <= irShift[1];
					irShift <= {sampleTdi, irShift[3:1]};
				end else if (armDr) begin
					if (sel == 2'h0) begin
						tdo       <= sampleTdi;
						bypassBit <= sampleTdi;
					end else begin
						tdo      <= bsrShift[1];
						bsrShift <= {sampleTdi, bsrShift[LEN-1:1]};
					end
				end else if (st == `JBS_SHIR) begin
					tdo <= irShift[0];
				end else if (st == `JBS_SHDR) begin
					tdo <= (sel == 2'h0) ? bypassBit : bsrShift[0];
				end
				tdoOeN <= ~((st == `JBS_SHIR) || (st == `JBS_SHDR));
			end
			if (dbgIntReq && dbgIntTaken) begin
				dbgIntReq <= 1'b0;
				ir        <= `JBS_CMD_BYPASS;
			end
		end
	end

	// ********************************
	// command output and pin muxes
	// ********************************
	always @(posedge sys_clk) begin
		if (srst) begin
			cmdValid <= 1'b0;
			irOut    <= `JBS_CMD_BYPASS;
		end else if (cmdReady || !cmdValid) begin
			cmdValid <= bufOutValid;
			if (bufOutValid)
				irOut <= bufOutData;
		end
	end

	generate
		for (g = 0; g < NPIN; g = g + 1) begin : gPin
			always @(posedge sys_clk) begin
				if (srst) begin
					padOut[g] <= 1'b0;
					padOeN[g] <= 1'b1;
				end else if (extest) begin
					// without a preload latchValid stays low, so pins stay off
					padOut[g] <= bsrLatch[3*g+1];
					padOeN[g] <= bsrLatch[3*g+2] | ~latchValid;
				end else begin
					padOut[g] <= coreOut[g];
					padOeN[g] <= coreOeN[g];
				end
			end
		end
	endgenerate

	always @(posedge sys_clk) begin
		if (srst)
			coreIn <= {NIN{1'b0}};
		else
			coreIn <= pinIn;
	end
endmodule // jbs_scan

// >>> jbs_map.vh
// constants of the boundary-scan and command block of the serial debug port
// assumes inclusion by the scan block; definitions only
// Notes on behaviour
// - command 0001 loaded while processor sleeps wakes the processor
// - code 1111 selects one-bit bypass between data in and out, no system effect
// - code 0100 selects sample/preload, boundary chain on scan path
// - during sample/preload pins pass to core and core to pins unchanged
// - sample captures pin or core value at rising clock in capture-dr
// - preload moves shifted data into each cell's parallel output latch
// - code 0000 selects extest; input cells capture board values
// - under extest output pins are driven constantly from output latches; here they stay disabled until an update-dr sets latchValid
// - under extest captured output-cell values never drive the board
// - chain includes oscillator and bus clock pin cells
// - chain excludes power-on reset, manual reset and chip-active pins
// - chain excludes the test port's own five pins
// - loaded commands other than debug interrupt persist until a new one
// - taken debug interrupt command turns into bypass automatically
// - in standby commands are ignored but the tap machine keeps running
// - data in sampled on rising clock, data out changes on falling, driven only in shifts
// - test reset low forces test-logic-reset at once
// - each two-way pin has an active-low control cell enabling its output
`ifndef JBS_MAP_VH
`define JBS_MAP_VH
`define JBS_IR_W        4
`define JBS_CMD_EXTEST  4'h0
`define JBS_CMD_WAKE    4'h1
`define JBS_CMD_DBGINT  4'h2
`define JBS_CMD_SAMPLE  4'h4
`define JBS_CMD_BYPASS  4'hf
`define JBS_IR_CAPTURE  4'h1
// tap states
`define JBS_TLR   4'h0
`define JBS_RTI   4'h1
`define JBS_SDRS  4'h2
`define JBS_CDR   4'h3
`define JBS_SHDR  4'h4
`define JBS_E1DR  4'h5
`define JBS_PDR   4'h6
`define JBS_E2DR  4'h7
`define JBS_UDR   4'h8
`define JBS_SIRS  4'h9
`define JBS_CIR   4'ha
`define JBS_SHIR  4'hb
`define JBS_E1IR  4'hc
`define JBS_PIR   4'hd
`define JBS_E2IR  4'he
`define JBS_UIR   4'hf
`endif

// >>> jbs_buf2.v
// two-entry valid/ready buffer
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
module jbs_buf2 #(
	parameter W = 4
) (
	input  wire         sys_clk,
	input  wire         srst,
	input  wire         inValid,
	output wire         inReady,
	input  wire [W-1:0] inData,
	output wire         outValid,
	input  wire         outReady,
	output wire [W-1:0] outData
);
	reg [W-1:0] mem [0:1];
	reg         wrPtr;
	reg         rdPtr;
	reg [1:0]   count;
	wire        doWr = inValid && inReady;
	wire        doRd = outValid && outReady;
	assign inReady  = (count != 2'h2);
	assign outValid = (count != 2'h0);
	assign outData  = mem[rdPtr];
	always @(posedge sys_clk) begin
		if (srst) begin
			wrPtr <= 1'b0;
			rdPtr <= 1'b0;
			count <= 2'h0;
		end else begin
			if (doWr) begin
				mem[wrPtr] <= inData;
				wrPtr <= ~wrPtr;
			end
			if (doRd)
				rdPtr <= ~rdPtr;
			count <= count + {1'b0, doWr} - {1'b0, doRd};
		end
	end
endmodule // jbs_buf2

// >>> jbs_scan_chk.sv
// assertions on the scan block ports
// assumes a bind onto jbs_scan, sync reset srst
`timescale 1ns/1ps
module jbs_scan_chk #(
	parameter NPIN = 4,
	parameter NIN  = 4
) (
	input wire logic            sys_clk,
	input wire logic            srst,
	input wire logic            tck,
	input wire logic            trstN,
	input wire logic            tdo,
	input wire logic            tdoOeN,
	input wire logic            cpuSleep,
	input wire logic            cpuStandby,
	input wire logic            wakeReq,
	input wire logic            dbgIntReq,
	input wire logic            dbgIntTaken,
	input wire logic [3:0]      irOut,
	input wire logic            cmdValid,
	input wire logic            cmdReady,
	input wire logic [NPIN-1:0] padOeN
);
	// ****
	// properties
	// ****
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	property p_rst; disable iff (1'h0) srst |=> tdoOeN && (&padOeN) && !cmdValid; endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_trst; !trstN [*5] |-> tdoOeN; endproperty
	a_trst: assert property (p_trst) else $error("tdo driven in test reset");
	// synced fall seen a few cycles late, so allow a window
	property p_tdo; !tdoOeN && $changed(tdo) |-> !$past(tck,2) || !$past(tck,3) || !$past(tck,4) || !$past(tck,5); endproperty
	a_tdo: assert property (p_tdo) else $error("tdo moved without tck fall");
	property p_wake; wakeReq |-> (cpuSleep || $past(cpuSleep)) ##1 !wakeReq; endproperty
	a_wake: assert property (p_wake) else $error("bad wake pulse");
	property p_stby; $rose(cmdValid) |-> !($past(cpuStandby,2) && $past(cpuStandby,3) && $past(cpuStandby,4)); endproperty
	a_stby: assert property (p_stby) else $error("command taken in standby");
	property p_hold; cmdValid && !cmdReady |=> cmdValid && $stable(irOut); endproperty
	a_hold: assert property (p_hold) else $error("stalled command lost");
	property p_dbgclr; dbgIntReq && dbgIntTaken |-> ##[1:3] !dbgIntReq; endproperty
	a_dbgclr: assert property (p_dbgclr) else $error("debug request not cleared");
	property p_dbghold; dbgIntReq && !dbgIntTaken && trstN |=> dbgIntReq; endproperty
	a_dbghold: assert property (p_dbghold) else $error("debug request dropped");
	c_wake: cover property (wakeReq);
	c_dbg: cover property (dbgIntReq && dbgIntTaken);
	c_stall: cover property (cmdValid && !cmdReady);
endmodule // jbs_scan_chk
bind jbs_scan jbs_scan_chk #(.NPIN(NPIN), .NIN(NIN)) jbs_scan_chk_inst (.sys_clk(sys_clk), .srst(srst), .tck(tck),
	.trstN(trstN), .tdo(tdo), .tdoOeN(tdoOeN), .cpuSleep(cpuSleep), .cpuStandby(cpuStandby), .wakeReq(wakeReq),
	.dbgIntReq(dbgIntReq), .dbgIntTaken(dbgIntTaken), .irOut(irOut), .cmdValid(cmdValid), .cmdReady(cmdReady),
	.padOeN(padOeN));

// >>> jbs_tester.sv
// tester model for the scan port pins
// assumes the bench calls its tasks; tck stands low between frames
`timescale 1ns/1ps
module jbs_tester (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	output logic      trstN,
	input  wire logic tdo,
	input  wire logic tdoOeN
);
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h0;
		trstN = 1'h0;
	end
	// ****
	// tck cycle, 125 ns
	// ****
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#62.5;
		o = tdo;
		tck = 1'h1;
		#62.5;
		tck = 1'h0;
	endtask
	task automatic treset();
		logic o;
		trstN = 1'h0;
		#250;
		trstN = 1'h1;
		for (int i = 0; i < 5; i++) step(1'h1, 1'h0, o);
		step(1'h0, 1'h0, o);
	endtask
	task automatic shir(input logic [3:0] c);
		logic o;
		step(1'h1, 1'h0, o);
		step(1'h1, 1'h0, o);
		step(1'h0, 1'h0, o);
		step(1'h0, 1'h0, o);
		for (int i = 0; i < 4; i++) step(i == 3, c[i], o);
		step(1'h1, 1'h0, o);
		step(1'h0, 1'h0, o);
	endtask
	// next pattern goes in while the last result comes out
	task automatic shdr(input int n, input logic [7:0] din, output logic [7:0] dout);
		logic o;
		dout = 8'h00;
		step(1'h1, 1'h0, o);
		step(1'h0, 1'h0, o);
		step(1'h0, 1'h0, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'h1, 1'h0, o);
		step(1'h0, 1'h0, o);
	endtask
endmodule // jbs_tester

// >>> jbs_scan_tb.sv
// bench for the scan and command block
// assumes jbs_tester drives the port; one pin of each kind
`timescale 1ns/1ps
module jbs_scan_tb;
	logic sys_clk = 1'h0, srst = 1'h1, cpuSleep = 1'h0, cpuStandby = 1'h0, dbgIntTaken = 1'h0, cmdReady = 1'h0;
	logic busClkPin = 1'h1, tdo, tdoOeN, wakeReq, dbgIntReq, cmdValid;
	wire  tck, tms, tdi, trstN;
	logic [3:0] irOut;
	logic [0:0] pinIn = 1'h0, coreOut = 1'h0, coreOeN = 1'h1, padIn = 1'h1, coreIn, padOut, padOeN;
	logic [1:0] oscPins = 2'h2;
	logic [7:0] so;
	int errors = 0, checks_done = 0, wakeCount = 0;
	jbs_scan #(.NPIN(1), .NIN(1)) jbs_scan_inst (.sys_clk(sys_clk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi),
		.trstN(trstN), .tdo(tdo), .tdoOeN(tdoOeN), .cpuSleep(cpuSleep), .cpuStandby(cpuStandby), .wakeReq(wakeReq),
		.dbgIntReq(dbgIntReq), .dbgIntTaken(dbgIntTaken), .irOut(irOut), .cmdValid(cmdValid), .cmdReady(cmdReady),
		.pinIn(pinIn), .coreIn(coreIn), .coreOut(coreOut), .coreOeN(coreOeN), .padIn(padIn), .padOut(padOut),
		.padOeN(padOeN), .oscPins(oscPins), .busClkPin(busClkPin));
	jbs_tester jbs_tester_inst (.tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN), .tdo(tdo), .tdoOeN(tdoOeN));
	initial forever #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (wakeReq === 1'h1) wakeCount++;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic ld(input logic [3:0] c);
		jbs_tester_inst.shir(c);
	endtask
	// take one command, ready only after it was seen
	task automatic pop(input logic [3:0] exp);
		for (int i = 0; i < 100 && cmdValid !== 1'h1; i++) tick(1);
		chk(irOut, exp);
		@(posedge sys_clk) cmdReady <= 1'h1;
		@(posedge sys_clk) cmdReady <= 1'h0;
		#1;
	endtask
	task automatic bypass_chk();
		jbs_tester_inst.shdr(8, 8'h96, so);
		chk(so, 8'h2c);
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_reset();
		chk({tdoOeN, padOeN, cmdValid}, 8'h06);
		bypass_chk();
	endtask
	task automatic t_stall();
		ld(4'h4);
		ld(4'hf);
		pop(4'h4);
		pop(4'hf);
		bypass_chk();
	endtask
	task automatic t_sample();
		ld(4'h4);
		pop(4'h4);
		tick(3);
		chk({padOut, padOeN, coreIn}, {coreOut, coreOeN, pinIn});
		jbs_tester_inst.shdr(7, 8'h02, so);
		chk(so, 8'h55);
		chk({padOut, padOeN}, {coreOut, coreOeN});
	endtask
	task automatic t_extest();
		ld(4'h0);
		pop(4'h0);
		tick(5);
		chk({padOut, padOeN}, 8'h02);
		@(posedge sys_clk) padIn <= 1'h0;
		jbs_tester_inst.shdr(7, 8'h04, so);
		chk(so[0], 1'h0);
		tick(5);
		chk({padOut, padOeN}, 8'h01);
		ld(4'hf);
		pop(4'hf);
		chk({padOut, padOeN}, {coreOut, coreOeN});
	endtask
	task automatic t_wake();
		ld(4'h1);
		pop(4'h1);
		chk(wakeCount, 0);
		@(posedge sys_clk) cpuSleep <= 1'h1;
		ld(4'h1);
		pop(4'h1);
		chk(wakeCount, 1);
		@(posedge sys_clk) cpuSleep <= 1'h0;
	endtask
	task automatic t_dbg();
		ld(4'h2);
		pop(4'h2);
		chk(dbgIntReq, 1'h1);
		@(posedge sys_clk) dbgIntTaken <= 1'h1;
		@(posedge sys_clk) dbgIntTaken <= 1'h0;
		tick(4);
		chk(dbgIntReq, 1'h0);
		bypass_chk();
	endtask
	task automatic t_standby();
		ld(4'h4);
		pop(4'h4);
		@(posedge sys_clk) cpuStandby <= 1'h1;
		ld(4'h0);
		tick(50);
		chk(cmdValid, 1'h0);
		@(posedge sys_clk) cpuStandby <= 1'h0;
		// core drive differs from the extest latch, so a leaked load would show
		@(posedge sys_clk) begin
			coreOut <= 1'h1;
			coreOeN <= 1'h0;
		end
		tick(5);
		chk({padOut, padOeN}, {coreOut, coreOeN});
	endtask
	task final_report();
		$display("errors=%0d checks_done=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge sys_clk);
		srst <= 1'h0;
		tick(3);
		jbs_tester_inst.treset();
		tick(5);
		t_reset();
		t_stall();
		t_sample();
		t_extest();
		t_wake();
		t_dbg();
		t_standby();
		final_report();
	end
	// whole run is well under 60 us of tck frames
	initial begin
		#300000;
		errors++;
		final_report();
	end
endmodule // jbs_scan_tb
